// >>> rtl/pcd_top.sv
// clock synthesizer counters: input choice, pre-scale, lock, post-scale and routing
//
// Overview of operation
// - pins 0 and 1 feed the first synthesizer, pins 2 and 3 the second
// - a differential reference consumes both pins of its synthesizer as a pair
// - dividers a and b drive core clocks; divider e drives only external clock
// - fixed lines: first a to 1,2 and b to 0,3; second a 5,6, b 4,7
// - pre-scale and post-scale take 1 to 32, multiplier 2 to 32
// - reference is input over pre-scale; oscillator runs reference times multiplier
// - each output divides the oscillator; either core clock may use either divider
// - each divider picks one of eight equally spaced oscillator taps
// - each divider has an initial count delaying it by whole oscillator periods
// - coarse and fine phase together reach plus or minus 180 degrees
// - all phases are measured from one common zero-shifted reference
// - phase step is 45 degrees over the divide value
// - phase shift works on all three dividers in every feedback mode
// - each divider has its own high-time and low-time counts
// - duty step is 50 percent over the divide value
// - enable low holds all outputs low and drops lock; rising restarts
// - counter reset high resets dividers, clears outputs, drops lock
// - lock high while locked, low otherwise, may pulse while locking
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`include "pcd_regs.svh"
`default_nettype none
module pcd_top
  import pcd_pkg::*;
#(
  parameter int SYNTH_INDEX = 0,
  parameter int LOCK_MATCH  = `PCD_LOCK_MATCH
) (
  // clock, reset, clock enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // dedicated clock pins
  input  wire logic        dedicated_clock_pin_0,
  input  wire logic        dedicated_clock_pin_1,
  input  wire logic        dedicated_clock_pin_2,
  input  wire logic        dedicated_clock_pin_3,
  // control
  input  wire logic        synth_enable,
  input  wire logic        counter_reset,
  // clocks out and lock
  output logic             core_clock_out_a,
  output logic             core_clock_out_b,
  output logic             external_clock_out,
  output logic      [7:0]  global_line,
  output logic             locked
);
  localparam int          LINE_BASE = SYNTH_INDEX * 4;
  localparam logic [7:0]  LINE_MASK = 8'h0f << LINE_BASE;
  localparam logic [3:0]  MATCH_TOP = 4'(LOCK_MATCH);

  pcd_dphase_t   dph_q;
  pcd_ctrl_t     ctrl_q;
  pcd_ctrl_t     act_q;
  pcd_loop_cfg_t loop_q;
  pcd_loop_cfg_t lact_q;
  pcd_div_cfg_t  div_q [3];
  pcd_div_cfg_t  wr_div;
  pcd_lock_st_t  lst_q;
  logic [2:0]    div_out;
  logic [2:0]    div_err;
  logic          loop_err;
  logic          err_clr;
  logic          cfg_err_q;
  logic [31:0]   rd_val;
  logic          run_d;
  logic          run_q;
  logic          load_d;
  logic [1:0]    pin_pair;
  logic          ref_lvl;
  logic          ref_q;
  logic          ref_prev_q;
  logic [5:0]    pre_cnt_q;
  logic          ref_tick_q;
  logic [2:0]    osc_phase_q;
  logic          osc_wrap;
  logic [6:0]    per_q;
  logic [3:0]    match_q;

  //////////////////////////////////////////////////////////////////////////
  // parameter check
  if (SYNTH_INDEX < 0 || SYNTH_INDEX > 1 || LOCK_MATCH < 1 || LOCK_MATCH > 15) begin : g_bad
    $error("pcd_top: SYNTH_INDEX must be 0 or 1 and LOCK_MATCH 1 to 15");
  end

  //////////////////////////////////////////////////////////////////////////
  // value checks; a divider is legal when its half counts sum to an even 2..64, high is nonzero and low is 2 or more unless the sum is 2
  function automatic logic div_ok(pcd_div_cfg_t c);
    logic [7:0] s;
    s = {1'b0, c.high} + {1'b0, c.low};
    div_ok = !s[0] && s >= 8'h02 && s <= `PCD_HALF_MAX && c.high != 7'h00
      && (c.low >= 7'h02 || s == 8'h02);
  endfunction : div_ok

  function automatic logic loop_ok(logic [5:0] pre, logic [5:0] mult);
    loop_ok = pre >= `PCD_DIV_MIN && pre <= `PCD_DIV_MAX
      && mult >= `PCD_MUL_MIN && mult <= `PCD_DIV_MAX;
  endfunction : loop_ok

  //////////////////////////////////////////////////////////////////////////
  // bus: zero wait states, always okay; read data sampled at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q     <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        dph_q.valid <= hsel && htrans[1] && haddr[31:8] == 24'h00_0000;
        dph_q.write <= hwrite && hsize == 3'h2;
        dph_q.addr  <= haddr[7:0];
        hrdata      <= rd_val;
      end
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (haddr[7:0])
      `PCD_CTRL_OFS: rd_val = {28'h000_0000, ctrl_q.src_b, ctrl_q.src_a, ctrl_q.pin, ctrl_q.diff};
      `PCD_LOOP_OFS: rd_val = {18'h0_0000, loop_q.mult, 2'h0, loop_q.pre};
      `PCD_DIVA_OFS: rd_val = {5'h00, div_q[0].tap, 3'h0, div_q[0].init, 1'b0, div_q[0].low,
                               1'b0, div_q[0].high};
      `PCD_DIVB_OFS: rd_val = {5'h00, div_q[1].tap, 3'h0, div_q[1].init, 1'b0, div_q[1].low,
                               1'b0, div_q[1].high};
      `PCD_DIVE_OFS: rd_val = {5'h00, div_q[2].tap, 3'h0, div_q[2].init, 1'b0, div_q[2].low,
                               1'b0, div_q[2].high};
      `PCD_STAT_OFS: rd_val = {29'h0000_0000, run_q, cfg_err_q, locked};
      default:       rd_val = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // control and loop registers; an illegal loop write is dropped whole
  assign loop_err = dph_q.valid && dph_q.write && dph_q.addr == `PCD_LOOP_OFS
    && !loop_ok(hwdata[`PCD_PRE_LSB +: 6], hwdata[`PCD_MUL_LSB +: 6]);
  assign err_clr  = dph_q.valid && dph_q.write && dph_q.addr == `PCD_STAT_OFS
    && hwdata[`PCD_ST_ERR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q      <= `PCD_CTRL_RST;
      loop_q.pre  <= `PCD_PRE_RST;
      loop_q.mult <= `PCD_MUL_RST;
    end else if (ce && dph_q.valid && dph_q.write) begin
      if (dph_q.addr == `PCD_CTRL_OFS) begin
        ctrl_q.diff  <= hwdata[`PCD_CTRL_DIFF];
        ctrl_q.pin   <= hwdata[`PCD_CTRL_PIN];
        ctrl_q.src_a <= hwdata[`PCD_CTRL_SRCA];
        ctrl_q.src_b <= hwdata[`PCD_CTRL_SRCB];
      end
      if (dph_q.addr == `PCD_LOOP_OFS && !loop_err) begin
        loop_q.pre  <= hwdata[`PCD_PRE_LSB +: 6];
        loop_q.mult <= hwdata[`PCD_MUL_LSB +: 6];
      end
    end
  end

  // divider setting as carried in a write
  assign wr_div.high = hwdata[`PCD_HI_LSB +: 7];
  assign wr_div.low  = hwdata[`PCD_LO_LSB +: 7];
  assign wr_div.init = hwdata[`PCD_INIT_LSB +: 5];
  assign wr_div.tap  = hwdata[`PCD_TAP_LSB +: 3];

  // one register per divider; illegal high/low pairs are refused
  for (genvar i = 0; i < 3; i++) begin : g_divreg
    localparam logic [7:0] OFS = `PCD_DIVA_OFS + 8'(4 * i);
    assign div_err[i] = dph_q.valid && dph_q.write && dph_q.addr == OFS && !div_ok(wr_div);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        div_q[i]      <= '0;
        div_q[i].high <= `PCD_HI_RST;
        div_q[i].low  <= `PCD_LO_RST;
      end else if (ce && dph_q.valid && dph_q.write && dph_q.addr == OFS && !div_err[i]) begin
        div_q[i] <= wr_div;
      end
    end
  end

  // sticky refusal flag; a new refusal beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_err_q <= 1'b0;
    end else if (ce) begin
      if (loop_err || div_err != 3'h0) begin
        cfg_err_q <= 1'b1;
      end else if (err_clr) begin
        cfg_err_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // run and load: enable high and counter reset low; load on release
  assign run_d  = synth_enable && !counter_reset;
  assign load_d = run_d && !run_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q  <= 1'b0;
      act_q  <= `PCD_CTRL_RST;
      lact_q <= {`PCD_MUL_RST, `PCD_PRE_RST};
    end else if (ce) begin
      run_q <= run_d;
      if (load_d) begin
        // settings change the running counters only at the next restart
        act_q  <= ctrl_q;
        lact_q <= loop_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reference choice: each synthesizer sees only its own pin pair
  assign pin_pair = (SYNTH_INDEX == 0)
    ? {dedicated_clock_pin_1, dedicated_clock_pin_0}
    : {dedicated_clock_pin_3, dedicated_clock_pin_2};
  assign ref_lvl  = act_q.diff ? (pin_pair[0] && !pin_pair[1]) : pin_pair[act_q.pin];

  // pre-scale: one reference tick every pre rising edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_q      <= 1'b0;
      ref_prev_q <= 1'b0;
      pre_cnt_q  <= 6'h00;
      ref_tick_q <= 1'b0;
    end else if (ce) begin
      ref_q      <= ref_lvl;
      ref_prev_q <= ref_q;
      ref_tick_q <= 1'b0;
      if (!run_d || load_d) begin
        pre_cnt_q <= 6'h00;
      end else if (ref_q && !ref_prev_q) begin
        if (pre_cnt_q == lact_q.pre - 6'h01) begin
          pre_cnt_q  <= 6'h00;
          ref_tick_q <= 1'b1;
        end else begin
          pre_cnt_q <= pre_cnt_q + 6'h01;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // oscillator model: eight taps, one clock each; restarts at load so
  // every divider shares the same zero phase
  assign osc_wrap = (osc_phase_q == `PCD_OSC_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_phase_q <= 3'h0;
      per_q       <= 7'h00;
    end else if (ce) begin
      if (!run_d || load_d) begin
        osc_phase_q <= 3'h0;
        per_q       <= 7'h00;
      end else begin
        osc_phase_q <= osc_phase_q + 3'h1;
        // oscillator periods seen in one reference period
        if (ref_tick_q) begin
          per_q <= {6'h00, osc_wrap};
        end else if (osc_wrap && per_q != 7'h7f) begin
          per_q <= per_q + 7'h01;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // lock detect: reference period must hold mult oscillator periods for
  // LOCK_MATCH ticks in a row; one miss drops lock, so it can pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lst_q   <= PCD_OFF;
      match_q <= 4'h0;
      locked  <= 1'b0;
    end else if (ce) begin
      if (!run_d || load_d) begin
        lst_q   <= run_d ? PCD_SEEK : PCD_OFF;
        match_q <= 4'h0;
        locked  <= 1'b0;
      end else begin
        unique case (lst_q)
          PCD_OFF: begin
            lst_q <= PCD_SEEK;
          end
          PCD_SEEK: begin
            if (ref_tick_q) begin
              if (per_q == {1'b0, lact_q.mult}) begin
                match_q <= match_q + 4'h1;
                if (match_q + 4'h1 == MATCH_TOP) begin
                  lst_q  <= PCD_LOCK;
                  locked <= 1'b1;
                end
              end else begin
                match_q <= 4'h0;
              end
            end
          end
          PCD_LOCK: begin
            if (ref_tick_q && per_q != {1'b0, lact_q.mult}) begin
              lst_q   <= PCD_SEEK;
              match_q <= 4'h0;
              locked  <= 1'b0;
            end
          end
          default: begin
            lst_q  <= PCD_OFF;
            locked <= 1'b0;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // three post-scale dividers: a, b, external; each with its own tap,
  // initial count and duty counts
  for (genvar i = 0; i < 3; i++) begin : g_div
    pcd_div u_div (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .ce        (ce),
      .run       (run_d),
      .load      (load_d),
      .osc_phase (osc_phase_q),
      .cfg       (div_q[i]),
      .div_out   (div_out[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // output stage: registered, low whenever the dividers are stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_clock_out_a   <= 1'b0;
      core_clock_out_b   <= 1'b0;
      external_clock_out <= 1'b0;
    end else if (ce) begin
      core_clock_out_a   <= act_q.src_a ? div_out[1] : div_out[0];
      core_clock_out_b   <= act_q.src_b ? div_out[1] : div_out[0];
      external_clock_out <= div_out[2];
    end
  end

  // fixed global line map; the external divider never reaches a line
  for (genvar l = 0; l < 8; l++) begin : g_line
    localparam int J = l - LINE_BASE;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        global_line[l] <= 1'b0;
      end else if (ce) begin
        if (J == 1 || J == 2) begin
          global_line[l] <= div_out[0];
        end else if (J == 0 || J == 3) begin
          global_line[l] <= div_out[1];
        end else begin
          global_line[l] <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_stop;
    ce && !run_d;
  endsequence
  sequence s_stop_held;
    s_stop ##1 ce;
  endsequence

  a_stop_clears: assert property (s_stop_held |=> !core_clock_out_a && !core_clock_out_b
      && !external_clock_out && !locked)
    else $error("outputs not cleared after stop");
  a_lock_cause: assert property ($rose(locked) |-> $past(ref_tick_q)
      && $past(per_q) == {1'b0, lact_q.mult})
    else $error("lock rose without a matching period");
  a_line_map: assert property (global_line[LINE_BASE + 1] == global_line[LINE_BASE + 2]
      && global_line[LINE_BASE] == global_line[LINE_BASE + 3]
      && (global_line & ~LINE_MASK) == 8'h00)
    else $error("global line map broken");
  a_core_select: assert property (ce |=> core_clock_out_b
      == ($past(act_q.src_b) ? $past(div_out[1]) : $past(div_out[0])))
    else $error("core clock b from wrong divider");
  a_loop_range: assert property (loop_ok(loop_q.pre, loop_q.mult))
    else $error("loop setting out of range");
  a_load_restart: assert property (ce && load_d |=> osc_phase_q == 3'h0
      && pre_cnt_q == 6'h00 && act_q == $past(ctrl_q))
    else $error("counters not restarted at release");
  a_err_wins: assert property (ce && (loop_err || div_err != 3'h0) |=> cfg_err_q)
    else $error("refusal flag lost");
endmodule : pcd_top
`default_nettype wire

// >>> rtl/pcd_regs.svh
// register offsets, field positions, limits and reset values of the clock counter block
`ifndef PCD_REGS_SVH
`define PCD_REGS_SVH
// byte offsets on the register bus
`define PCD_CTRL_OFS 8'h00
`define PCD_LOOP_OFS 8'h04
`define PCD_DIVA_OFS 8'h08
`define PCD_DIVB_OFS 8'h0c
`define PCD_DIVE_OFS 8'h10
`define PCD_STAT_OFS 8'h14
// control fields
`define PCD_CTRL_DIFF 0
`define PCD_CTRL_PIN 1
`define PCD_CTRL_SRCA 2
`define PCD_CTRL_SRCB 3
// loop fields
`define PCD_PRE_LSB 0
`define PCD_MUL_LSB 8
// divider fields
`define PCD_HI_LSB 0
`define PCD_LO_LSB 8
`define PCD_INIT_LSB 16
`define PCD_TAP_LSB 24
// status fields
`define PCD_ST_LOCK 0
`define PCD_ST_ERR 1
`define PCD_ST_RUN 2
// value limits
`define PCD_DIV_MIN 6'h01
`define PCD_DIV_MAX 6'h20
`define PCD_MUL_MIN 6'h02
`define PCD_HALF_MAX 8'h40
// reset values
`define PCD_CTRL_RST 4'h0
`define PCD_PRE_RST 6'h01
`define PCD_MUL_RST 6'h02
`define PCD_HI_RST 7'h01
`define PCD_LO_RST 7'h01
// last oscillator phase tap, one clock cycle per tap, so the period is eight cycles
`define PCD_OSC_LAST 3'h7
`define PCD_LOCK_MATCH 4
`endif

// >>> rtl/pcd_pkg.sv
// types shared by the clock counter block
`default_nettype none
package pcd_pkg;
  // one post-scale divider setting, high and low counts in half oscillator periods, initial count in whole ones
  typedef struct packed {
    logic [2:0] tap;
    logic [4:0] init;
    logic [6:0] low;
    logic [6:0] high;
  } pcd_div_cfg_t;
  // pre-scale and feedback values
  typedef struct packed {
    logic [5:0] mult;
    logic [5:0] pre;
  } pcd_loop_cfg_t;
  // input choice and core output routing
  typedef struct packed {
    logic diff;
    logic pin;
    logic src_a;
    logic src_b;
  } pcd_ctrl_t;
  // bus data phase held from the address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } pcd_dphase_t;
  // lock detector states
  typedef enum logic [2:0] {
    PCD_OFF  = 3'b001,
    PCD_SEEK = 3'b010,
    PCD_LOCK = 3'b100
  } pcd_lock_st_t;
endpackage : pcd_pkg
`default_nettype wire

// >>> rtl/pcd_div.sv
// one post-scale divider with tap choice, initial delay and high/low counts
`include "pcd_regs.svh"
`default_nettype none
module pcd_div
  import pcd_pkg::*;
(
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  // control from the counter block
  input  wire logic         run,
  input  wire logic         load,
  input  wire logic [2:0]   osc_phase,
  input  wire pcd_div_cfg_t cfg,
  // divided clock
  output logic              div_out
);
  pcd_div_cfg_t cfg_q;
  logic [4:0]   wait_q;
  logic [6:0]   cnt_q;
  logic         started_q;
  logic         full_tick;
  logic         half_tick;

  //////////////////////////////////////////////////////////////////////////
  // ticks on the chosen tap: whole period and half period
  assign full_tick = (osc_phase == cfg_q.tap);
  assign half_tick = (osc_phase[1:0] == cfg_q.tap[1:0]);

  //////////////////////////////////////////////////////////////////////////
  // counting; settings are only taken at load so all outputs restart together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q     <= '0;
      wait_q    <= 5'h00;
      cnt_q     <= 7'h00;
      started_q <= 1'b0;
      div_out   <= 1'b0;
    end else if (ce) begin
      if (!run || load) begin
        // stopped output is low; the initial count is reloaded only at load
        started_q <= 1'b0;
        div_out   <= 1'b0;
        if (load) begin
          cfg_q  <= cfg;
          wait_q <= cfg.init;
        end
      end else if (!started_q) begin
        // coarse offset in whole oscillator periods
        if (full_tick) begin
          if (wait_q == 5'h00) begin
            started_q <= 1'b1;
            div_out   <= 1'b1;
            cnt_q     <= cfg_q.high;
          end else begin
            wait_q <= wait_q - 5'h01;
          end
        end
      end else if (half_tick) begin
        // alternate high and low phases
        if (cnt_q == 7'h01) begin
          div_out <= !div_out;
          cnt_q   <= div_out ? cfg_q.low : cfg_q.high;
        end else begin
          cnt_q <= cnt_q - 7'h01;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_tap_edge: assert property ($rose(div_out) |-> $past(osc_phase[1:0]) == cfg_q.tap[1:0])
    else $error("divider rose off its tap");
  a_wait_low: assert property (!started_q |-> !div_out)
    else $error("divider high before initial count");
  a_phase_end: assert property (ce && run && !load && started_q && half_tick && cnt_q == 7'h01
      |=> div_out != $past(div_out))
    else $error("divider phase did not end on count");
  a_phase_hold: assert property (ce && run && !load && started_q && cnt_q > 7'h01
      |=> div_out == $past(div_out))
    else $error("divider phase ended early");
endmodule : pcd_div
`default_nettype wire

// >>> verif/pcd_ref_src.sv
// reference clock source standing on the dedicated pins of the first synthesizer
`default_nettype none
module pcd_ref_src #(
  parameter int HALF = 8
) (
  // bench clock and gate
  input  wire logic hclk,
  input  wire logic run,
  // dedicated pin pair
  output var  logic pin_lo,
  output wire logic pin_hi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q = 8'h00;
  ////////////////////////////////////////////////////////////////
  // square wave only while run, so the pin stands still between uses
  always @(posedge hclk) begin
    if (!run) begin
      cnt_q  <= 8'h00;
      pin_lo <= 1'b0;
    end else if (cnt_q == 8'(HALF - 1)) begin
      cnt_q  <= 8'h00;
      pin_lo <= ~pin_lo;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // complement leg of the pair, a true clock pin, never fabric logic
  assign pin_hi = ~pin_lo;
endmodule : pcd_ref_src
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench of the clock counter block
`include "pcd_regs.svh"
`default_nettype none
module tb_top;
  import pcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, en = 1'b0, crst = 1'b0, ref_run = 1'b0;
  logic ce_in = 1'b1, sel = 1'b1;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, ca, cb, ce_o, lck, p0, p1;
  logic [7:0] gl;
  int fails = 0, comparisons = 0, hi, lo;
  always #20 hclk = ~hclk;
  pcd_ref_src #(.HALF(8)) pcd_ref_src_i (.hclk(hclk), .run(ref_run), .pin_lo(p0), .pin_hi(p1));
  pcd_top #(.SYNTH_INDEX(0), .LOCK_MATCH(2)) pcd_top_i (.hclk(hclk), .hresetn(hresetn), .ce(ce_in),
    .hsel(sel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .dedicated_clock_pin_0(p0), .dedicated_clock_pin_1(p1), .dedicated_clock_pin_2(1'b0),
    .dedicated_clock_pin_3(1'b0), .synth_enable(en), .counter_reset(crst),
    .core_clock_out_a(ca), .core_clock_out_b(cb), .external_clock_out(ce_o), .global_line(gl),
    .locked(lck));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one ahb single transfer; address held until hready, then data phase until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // wait for a rise of core a, then count its high and low cycles
  task automatic meas();
    int n;
    n = 0;
    while (ca !== 1'b0 && n < 300) begin @(posedge hclk); #1; n++; end
    while (ca !== 1'b1 && n < 600) begin @(posedge hclk); #1; n++; end
    hi = 0;
    lo = 0;
    while (ca === 1'b1 && hi < 300) begin @(posedge hclk); #1; hi++; end
    while (ca === 1'b0 && lo < 300) begin @(posedge hclk); #1; lo++; end
  endtask : meas
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(1'b0, `PCD_LOOP_OFS, 0);  chk(rd, 32'h0000_0201);
    // a write while deselected must leave the divider alone
    sel <= 1'b0;
    bus(1'b1, `PCD_DIVA_OFS, 32'h0000_0402);
    sel <= 1'b1;
    bus(1'b0, `PCD_DIVA_OFS, 0);  chk(rd, 32'h0000_0101);
    bus(1'b0, 8'h40, 0);          chk(rd, 32'h0);
    // a write of the wrong size is ignored, not refused
    hsize <= 3'h0;
    bus(1'b1, `PCD_LOOP_OFS, 32'h0000_0302);
    hsize <= 3'h2;
    bus(1'b1, `PCD_LOOP_OFS, 32'h0000_0101);
    bus(1'b0, `PCD_LOOP_OFS, 0);  chk(rd, 32'h0000_0201);
    bus(1'b0, `PCD_STAT_OFS, 0);  chk(rd[1], 1'b1);
    bus(1'b1, `PCD_DIVB_OFS, 32'h0000_0103);
    bus(1'b0, `PCD_DIVB_OFS, 0);  chk(rd, 32'h0000_0101);
    bus(1'b1, `PCD_STAT_OFS, 32'h2);
    bus(1'b0, `PCD_STAT_OFS, 0);  chk({rd[1], hresp}, 2'b00);
    $display("t_regs done");
  endtask : t_regs
  // divide 3 on divider a: high 2, low 4 half periods of an 8-cycle oscillator
  task automatic t_duty();
    // core b taken from divider b, so both line pairs are watched
    bus(1'b1, `PCD_CTRL_OFS, 32'h8);
    bus(1'b1, `PCD_DIVA_OFS, 32'h0000_0402);
    en <= 1'b1;
    meas();
    chk(hi, 8);
    chk(lo, 16);
    repeat (10) begin
      @(posedge hclk);
      #1;
      chk({gl[7:4], gl[3], gl[0], gl[2], gl[1]}, {4'h0, cb, cb, ca, ca});
    end
    // clock enable low freezes every output; divider b would flip every 4 cycles
    @(posedge hclk);
    ce_in <= 1'b0;
    #1;
    rd = {22'h0, ca, cb, gl};
    repeat (20) @(posedge hclk);
    #1;
    chk({22'h0, ca, cb, gl}, rd);
    @(posedge hclk);
    ce_in <= 1'b1;
    $display("t_duty done");
  endtask : t_duty
  // core a moved to divider b, taken only at the counter reset release
  task automatic t_swap();
    bus(1'b1, `PCD_CTRL_OFS, 32'h4);
    meas();
    chk(hi, 8);
    @(posedge hclk);
    crst <= 1'b1;
    repeat (3) @(posedge hclk);
    #1;
    chk({ca, cb, ce_o, gl, lck}, 0);
    @(posedge hclk);
    crst <= 1'b0;
    meas();
    chk({hi[7:0], lo[7:0]}, 16'h0404);
    $display("t_swap done");
  endtask : t_swap
  // reference at eight times mult over pre cycles brings lock, enable low drops all
  task automatic t_lock();
    int n;
    ref_run <= 1'b1;
    n = 0;
    while (lck !== 1'b1 && n < 800) begin @(posedge hclk); #1; n++; end
    chk(lck, 1'b1);
    @(posedge hclk);
    en <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    chk({ca, cb, ce_o, gl, lck}, 0);
    $display("t_lock done");
  endtask : t_lock
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // watchdog well past the few hundred cycles the tests need
  initial begin
    #800000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_regs();
    t_duty();
    t_swap();
    t_lock();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
